//--- hw/pppc_pkg.sv
// Shared constants for the parallel port pin control block
package pppc_pkg;
  localparam int ADDR_W = 8;
  // Register map: port index in addr[6:4], register select in addr[3:2]
  localparam logic [1:0] SEL_DIR = 2'h0;
  localparam logic [1:0] SEL_LATCH = 2'h1;
  localparam logic [1:0] SEL_PIN = 2'h2;
  localparam logic [1:0] SEL_CTL = 2'h3;
  localparam int IDX_LSB = 4;
  localparam int SEL_LSB = 2;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h80;
  // Port indices
  localparam logic [2:0] IDX_P1 = 3'h0;
  localparam logic [2:0] IDX_P2 = 3'h1;
  localparam logic [2:0] IDX_P3 = 3'h2;
  localparam logic [2:0] IDX_P5 = 3'h3;
  localparam logic [2:0] IDX_PA = 3'h4;
  localparam logic [2:0] IDX_PB = 3'h5;
  localparam logic [2:0] IDX_PC = 3'h6;
  localparam logic [2:0] IDX_P4 = 3'h7;
  // Control word layout: pull-up enables low byte, open-drain high byte
  localparam int CTL_PU_LSB = 0;
  localparam int CTL_OD_LSB = 8;
  // Port widths
  localparam int W_P1 = 8;
  localparam int W_P2 = 8;
  localparam int W_P3 = 6;
  localparam int W_P4 = 4;
  localparam int W_P5 = 4;
  localparam int W_PA = 4;
  localparam int W_PB = 8;
  localparam int W_PC = 8;
  // Reset values
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    MODE_1 = 3'b001,
    MODE_2 = 3'b010,
    MODE_3 = 3'b011,
    MODE_4 = 3'b100,
    MODE_5 = 3'b101,
    MODE_6 = 3'b110,
    MODE_7 = 3'b111
  } pppc_mode_type;
  localparam pppc_mode_type RST_MODE = MODE_7;
endpackage

//--- hw/pppc_input_port.sv
// Input-only port: samples pin levels for the read path
`timescale 1ns/1ps
module pppc_input_port #(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pinIn,
  output logic      [7:0]   rdPin
);
  logic [W-1:0] level_r;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      level_r <= '0;
    else
      level_r <= pinIn; // RL4
  end

  assign rdPin = 8'(level_r); // RL3
endmodule

//--- hw/pppc_port.sv
// One bidirectional port: direction, latch, pull-up, open drain, pin mux
`timescale 1ns/1ps
module pppc_port #(
  parameter int W      = 8,
  parameter bit HAS_PU = 1'b0,
  parameter bit HAS_OD = 1'b0
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         wrDir,
  input  wire logic         wrLatch,
  input  wire logic         wrCtl,
  input  wire logic [15:0]  wrData,
  input  wire logic [1:0]   wrStrb,
  input  wire logic [W-1:0] addrSel,
  input  wire logic [W-1:0] addrVal,
  input  wire logic [W-1:0] altOwn,
  input  wire logic [W-1:0] altOe,
  input  wire logic [W-1:0] altOut,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut,
  output logic      [W-1:0] pinOe,
  output logic      [W-1:0] pullEn,
  output logic      [7:0]   rdDir,
  output logic      [7:0]   rdLatch,
  output logic      [7:0]   rdPin,
  output logic      [15:0]  rdCtl
);
  logic [W-1:0] dir_r;
  logic [W-1:0] latch_r;
  logic [W-1:0] pu_r;
  logic [W-1:0] od_r;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      dir_r <= W'(pppc_pkg::RST_DIR);
    else if (wrDir && wrStrb[0])
      dir_r <= wrData[W-1:0]; // RL1
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      latch_r <= W'(pppc_pkg::RST_LATCH);
    else if (wrLatch && wrStrb[0])
      latch_r <= wrData[W-1:0]; // RL2
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pu_r <= W'(pppc_pkg::RST_CTL);
    else if (HAS_PU && wrCtl && wrStrb[0])
      pu_r <= wrData[pppc_pkg::CTL_PU_LSB +: W]; // RL5
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      od_r <= W'(pppc_pkg::RST_CTL);
    else if (HAS_OD && wrCtl && wrStrb[1])
      od_r <= wrData[pppc_pkg::CTL_OD_LSB +: W]; // RL6
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic drvVal;
      logic drvEn;
      // Peripheral, then address, then latch
      assign drvVal = altOwn[i] ? altOut[i] :
                      addrSel[i] ? addrVal[i] : latch_r[i]; // RL12
      assign drvEn  = altOwn[i] ? altOe[i] :
                      addrSel[i] ? 1'b1 : dir_r[i]; // RL1
      assign pinOut[i] = drvVal; // RL2
      // Open drain: high side off, pin only pulls low
      assign pinOe[i]  = drvEn && !(od_r[i] && drvVal); // RL6
      // Pull-up only on undriven pins
      assign pullEn[i] = pu_r[i] && !drvEn; // RL5
    end
  endgenerate

  assign rdDir   = 8'(dir_r);
  assign rdLatch = 8'(latch_r);
  assign rdPin   = 8'(pinIn); // RL3
  assign rdCtl   = {8'(od_r), 8'(pu_r)};
endmodule

//--- hw/pppc_top.sv
// Port pin control top: AXI4-Lite register slave and port instances
`timescale 1ns/1ps
// What this block does
// RL1: Per-pin direction bit on every bidirectional port
// RL2: Output latch drives pins set as outputs
// RL3: Read-only path returns pin levels
// RL4: Port 4 is four input-only pins
// RL5: Ports A-C have per-pin pull-up enables
// RL6: Ports 3 and A have open-drain bits
// RL7: Port 1 low nibble: direction selects address in modes 4-6
// RL8: Port 3 six pins shared with serial, interrupts
// RL9: Port 2 eight pins shared with timers
// RL10: Port 5 four pins, three shared with serial
// RL11: Ports A-C address use chosen per mode
// RL12: Owning peripheral replaces latch and direction
module pppc_top (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [23:0] addrBus,
  input  wire logic [7:0]  p1In,
  output logic      [7:0]  p1Out,
  output logic      [7:0]  p1Oe,
  input  wire logic [7:0]  p1AltOwn,
  input  wire logic [7:0]  p1AltOe,
  input  wire logic [7:0]  p1AltOut,
  input  wire logic [7:0]  p2In,
  output logic      [7:0]  p2Out,
  output logic      [7:0]  p2Oe,
  input  wire logic [7:0]  p2AltOwn,
  input  wire logic [7:0]  p2AltOe,
  input  wire logic [7:0]  p2AltOut,
  input  wire logic [5:0]  p3In,
  output logic      [5:0]  p3Out,
  output logic      [5:0]  p3Oe,
  input  wire logic [5:0]  p3AltOwn,
  input  wire logic [5:0]  p3AltOe,
  input  wire logic [5:0]  p3AltOut,
  input  wire logic [3:0]  p4In,
  input  wire logic [3:0]  p5In,
  output logic      [3:0]  p5Out,
  output logic      [3:0]  p5Oe,
  input  wire logic [3:0]  p5AltOwn,
  input  wire logic [3:0]  p5AltOe,
  input  wire logic [3:0]  p5AltOut,
  input  wire logic [3:0]  paIn,
  output logic      [3:0]  paOut,
  output logic      [3:0]  paOe,
  output logic      [3:0]  paPullEn,
  input  wire logic [7:0]  pbIn,
  output logic      [7:0]  pbOut,
  output logic      [7:0]  pbOe,
  output logic      [7:0]  pbPullEn,
  input  wire logic [7:0]  pcIn,
  output logic      [7:0]  pcOut,
  output logic      [7:0]  pcOe,
  output logic      [7:0]  pcPullEn,
  output logic      [2:0]  modeOut
);
  // Write channel capture
  logic                      awHave_r;
  logic [pppc_pkg::ADDR_W-1:0] awAddr_r;
  logic                      wHave_r;
  logic [31:0]               wData_r;
  logic [3:0]                wStrb_r;
  logic                      bValid_r;
  logic [1:0]                bResp_r;
  logic                      rValid_r;
  logic [1:0]                rResp_r;
  logic [31:0]               rData_r;
  pppc_pkg::pppc_mode_type   mode_r;
  logic                      doWr;
  logic [2:0]                wIdx;
  logic [1:0]                wSel;
  logic                      wPortHit;
  logic                      wModeHit;
  logic [7:0]                wrDir;
  logic [7:0]                wrLatch;
  logic [7:0]                wrCtl;
  logic [7:0]                rdDir   [8];
  logic [7:0]                rdLatch [8];
  logic [7:0]                rdPin   [8];
  logic [15:0]               rdCtl   [8];
  logic                      expA;
  logic                      ddrA;
  logic                      fixBC;
  logic                      ddrBC;
  logic [7:0]                p1AddrSel;
  logic [3:0]                paAddrSel;
  logic [7:0]                pbAddrSel;
  logic [7:0]                pcAddrSel;
  logic [3:0]                paNone;
  logic [7:0]                pbNone;
  logic [7:0]                pcNone;
  logic [7:0]                p1PullNc;
  logic [7:0]                p2PullNc;
  logic [5:0]                p3PullNc;
  logic [3:0]                p5PullNc;

  assign s_axi_awready = !awHave_r;
  assign s_axi_wready  = !wHave_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rresp   = rResp_r;
  assign s_axi_rdata   = rData_r;
  assign modeOut       = mode_r;

  assign doWr = awHave_r && wHave_r && !bValid_r;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      awHave_r <= 1'b0;
      awAddr_r <= '0;
    end
    else if (s_axi_awvalid && !awHave_r)
    begin
      awHave_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end
    else if (doWr)
      awHave_r <= 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wHave_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
    end
    else if (s_axi_wvalid && !wHave_r)
    begin
      wHave_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end
    else if (doWr)
      wHave_r <= 1'b0;
  end

  // Write decode
  assign wIdx     = awAddr_r[pppc_pkg::IDX_LSB +: 3];
  assign wSel     = awAddr_r[pppc_pkg::SEL_LSB +: 2];
  assign wPortHit = (awAddr_r[7] == 1'b0);
  assign wModeHit = (awAddr_r == pppc_pkg::OFS_MODE);

  genvar k;
  generate
    for (k = 0; k < 8; k++)
    begin : g_wstb
      assign wrDir[k]   = doWr && wPortHit && wIdx == 3'(k) &&
                          wSel == pppc_pkg::SEL_DIR;
      assign wrLatch[k] = doWr && wPortHit && wIdx == 3'(k) &&
                          wSel == pppc_pkg::SEL_LATCH;
      assign wrCtl[k]   = doWr && wPortHit && wIdx == 3'(k) &&
                          wSel == pppc_pkg::SEL_CTL;
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bValid_r <= 1'b0;
      bResp_r  <= pppc_pkg::RESP_OKAY;
    end
    else if (doWr)
    begin
      bValid_r <= 1'b1;
      if (wModeHit || (wPortHit && wIdx != pppc_pkg::IDX_P4))
        bResp_r <= pppc_pkg::RESP_OKAY;
      else
        bResp_r <= pppc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bValid_r <= 1'b0;
  end

  // Mode code 0 is illegal; such writes are dropped
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mode_r <= pppc_pkg::RST_MODE;
    else if (doWr && wModeHit && wStrb_r[0] && wData_r[2:0] != 3'h0)
      mode_r <= pppc_pkg::pppc_mode_type'(wData_r[2:0]);
  end

  // Read path
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rValid_r <= 1'b0;
      rResp_r  <= pppc_pkg::RESP_OKAY;
      rData_r  <= '0;
    end
    else if (s_axi_arvalid && !rValid_r)
    begin
      rValid_r <= 1'b1;
      rResp_r  <= pppc_pkg::RESP_OKAY;
      rData_r  <= '0;
      if (s_axi_araddr == pppc_pkg::OFS_MODE)
        rData_r <= 32'(mode_r);
      else if (s_axi_araddr[7] == 1'b0)
      begin
        unique case (s_axi_araddr[pppc_pkg::SEL_LSB +: 2])
          pppc_pkg::SEL_DIR:
            rData_r <= 32'(rdDir[s_axi_araddr[pppc_pkg::IDX_LSB +: 3]]);
          pppc_pkg::SEL_LATCH:
            rData_r <= 32'(rdLatch[s_axi_araddr[pppc_pkg::IDX_LSB +: 3]]);
          pppc_pkg::SEL_PIN:
            rData_r <= 32'(rdPin[s_axi_araddr[pppc_pkg::IDX_LSB +: 3]]); // RL3
          pppc_pkg::SEL_CTL:
            rData_r <= 32'(rdCtl[s_axi_araddr[pppc_pkg::IDX_LSB +: 3]]);
        endcase
        if (s_axi_araddr[pppc_pkg::IDX_LSB +: 3] == pppc_pkg::IDX_P4 &&
            s_axi_araddr[pppc_pkg::SEL_LSB +: 2] != pppc_pkg::SEL_PIN)
        begin
          rResp_r <= pppc_pkg::RESP_SLVERR;
          rData_r <= '0;
        end
      end
      else
        rResp_r <= pppc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rValid_r <= 1'b0;
  end

  // Address selection per operating mode
  assign expA  = (mode_r == pppc_pkg::MODE_4) ||
                 (mode_r == pppc_pkg::MODE_5);
  assign ddrA  = (mode_r == pppc_pkg::MODE_6);
  assign fixBC = (mode_r == pppc_pkg::MODE_1) || expA;
  assign ddrBC = (mode_r == pppc_pkg::MODE_2) || ddrA;

  // Upper address on port 1 low nibble
  assign p1AddrSel = {4'h0,
    (expA || ddrA) ? rdDir[pppc_pkg::IDX_P1][3:0] : 4'h0}; // RL7
  assign paAddrSel = expA ? 4'hf :
                     ddrA ? rdDir[pppc_pkg::IDX_PA][3:0] : 4'h0; // RL11
  assign pbAddrSel = fixBC ? 8'hff :
                     ddrBC ? rdDir[pppc_pkg::IDX_PB] : 8'h00; // RL11
  assign pcAddrSel = fixBC ? 8'hff :
                     ddrBC ? rdDir[pppc_pkg::IDX_PC] : 8'h00; // RL11
  assign paNone = 4'h0;
  assign pbNone = 8'h00;
  assign pcNone = 8'h00;

  // Port 1: timer pins, upper address
  pppc_port #(.W(pppc_pkg::W_P1)) u_p1 (
    .mclk    (mclk),
    .rst     (rst),
    .wrDir   (wrDir[pppc_pkg::IDX_P1]),
    .wrLatch (wrLatch[pppc_pkg::IDX_P1]),
    .wrCtl   (wrCtl[pppc_pkg::IDX_P1]),
    .wrData  (wData_r[15:0]),
    .wrStrb  (wStrb_r[1:0]),
    .addrSel (p1AddrSel),
    .addrVal ({4'h0, addrBus[23:20]}),
    .altOwn  (p1AltOwn),
    .altOe   (p1AltOe),
    .altOut  (p1AltOut),
    .pinIn   (p1In),
    .pinOut  (p1Out),
    .pinOe   (p1Oe),
    .pullEn  (p1PullNc),
    .rdDir   (rdDir[pppc_pkg::IDX_P1]),
    .rdLatch (rdLatch[pppc_pkg::IDX_P1]),
    .rdPin   (rdPin[pppc_pkg::IDX_P1]),
    .rdCtl   (rdCtl[pppc_pkg::IDX_P1])
  );

  // Port 2: two 8-bit timer channels
  pppc_port #(.W(pppc_pkg::W_P2)) u_p2 ( // RL9
    .mclk    (mclk),
    .rst     (rst),
    .wrDir   (wrDir[pppc_pkg::IDX_P2]),
    .wrLatch (wrLatch[pppc_pkg::IDX_P2]),
    .wrCtl   (wrCtl[pppc_pkg::IDX_P2]),
    .wrData  (wData_r[15:0]),
    .wrStrb  (wStrb_r[1:0]),
    .addrSel (8'h00),
    .addrVal (8'h00),
    .altOwn  (p2AltOwn),
    .altOe   (p2AltOe),
    .altOut  (p2AltOut),
    .pinIn   (p2In),
    .pinOut  (p2Out),
    .pinOe   (p2Oe),
    .pullEn  (p2PullNc),
    .rdDir   (rdDir[pppc_pkg::IDX_P2]),
    .rdLatch (rdLatch[pppc_pkg::IDX_P2]),
    .rdPin   (rdPin[pppc_pkg::IDX_P2]),
    .rdCtl   (rdCtl[pppc_pkg::IDX_P2])
  );

  // Port 3: serial 0 and 1, two interrupts
  pppc_port #(.W(pppc_pkg::W_P3), .HAS_OD(1'b1)) u_p3 ( // RL8
    .mclk    (mclk),
    .rst     (rst),
    .wrDir   (wrDir[pppc_pkg::IDX_P3]),
    .wrLatch (wrLatch[pppc_pkg::IDX_P3]),
    .wrCtl   (wrCtl[pppc_pkg::IDX_P3]),
    .wrData  (wData_r[15:0]),
    .wrStrb  (wStrb_r[1:0]),
    .addrSel (6'h00),
    .addrVal (6'h00),
    .altOwn  (p3AltOwn),
    .altOe   (p3AltOe),
    .altOut  (p3AltOut),
    .pinIn   (p3In),
    .pinOut  (p3Out),
    .pinOe   (p3Oe),
    .pullEn  (p3PullNc),
    .rdDir   (rdDir[pppc_pkg::IDX_P3]),
    .rdLatch (rdLatch[pppc_pkg::IDX_P3]),
    .rdPin   (rdPin[pppc_pkg::IDX_P3]),
    .rdCtl   (rdCtl[pppc_pkg::IDX_P3])
  );

  // Port 4: input only, no direction or latch
  pppc_input_port #(.W(pppc_pkg::W_P4)) u_p4 ( // RL4
    .mclk  (mclk),
    .rst   (rst),
    .pinIn (p4In),
    .rdPin (rdPin[pppc_pkg::IDX_P4])
  );
  assign rdDir[pppc_pkg::IDX_P4]   = 8'h00;
  assign rdLatch[pppc_pkg::IDX_P4] = 8'h00;
  assign rdCtl[pppc_pkg::IDX_P4]   = 16'h0000;

  // Port 5: serial channel 2 on three pins
  pppc_port #(.W(pppc_pkg::W_P5)) u_p5 ( // RL10
    .mclk    (mclk),
    .rst     (rst),
    .wrDir   (wrDir[pppc_pkg::IDX_P5]),
    .wrLatch (wrLatch[pppc_pkg::IDX_P5]),
    .wrCtl   (wrCtl[pppc_pkg::IDX_P5]),
    .wrData  (wData_r[15:0]),
    .wrStrb  (wStrb_r[1:0]),
    .addrSel (4'h0),
    .addrVal (4'h0),
    .altOwn  ({1'b0, p5AltOwn[2:0]}),
    .altOe   (p5AltOe),
    .altOut  (p5AltOut),
    .pinIn   (p5In),
    .pinOut  (p5Out),
    .pinOe   (p5Oe),
    .pullEn  (p5PullNc),
    .rdDir   (rdDir[pppc_pkg::IDX_P5]),
    .rdLatch (rdLatch[pppc_pkg::IDX_P5]),
    .rdPin   (rdPin[pppc_pkg::IDX_P5]),
    .rdCtl   (rdCtl[pppc_pkg::IDX_P5])
  );

  pppc_port #(.W(pppc_pkg::W_PA), .HAS_PU(1'b1), .HAS_OD(1'b1)) u_pa (
    .mclk    (mclk),
    .rst     (rst),
    .wrDir   (wrDir[pppc_pkg::IDX_PA]),
    .wrLatch (wrLatch[pppc_pkg::IDX_PA]),
    .wrCtl   (wrCtl[pppc_pkg::IDX_PA]),
    .wrData  (wData_r[15:0]),
    .wrStrb  (wStrb_r[1:0]),
    .addrSel (paAddrSel),
    .addrVal (addrBus[19:16]),
    .altOwn  (paNone),
    .altOe   (paNone),
    .altOut  (paNone),
    .pinIn   (paIn),
    .pinOut  (paOut),
    .pinOe   (paOe),
    .pullEn  (paPullEn),
    .rdDir   (rdDir[pppc_pkg::IDX_PA]),
    .rdLatch (rdLatch[pppc_pkg::IDX_PA]),
    .rdPin   (rdPin[pppc_pkg::IDX_PA]),
    .rdCtl   (rdCtl[pppc_pkg::IDX_PA])
  );

  pppc_port #(.W(pppc_pkg::W_PB), .HAS_PU(1'b1)) u_pb (
    .mclk    (mclk),
    .rst     (rst),
    .wrDir   (wrDir[pppc_pkg::IDX_PB]),
    .wrLatch (wrLatch[pppc_pkg::IDX_PB]),
    .wrCtl   (wrCtl[pppc_pkg::IDX_PB]),
    .wrData  (wData_r[15:0]),
    .wrStrb  (wStrb_r[1:0]),
    .addrSel (pbAddrSel),
    .addrVal (addrBus[15:8]),
    .altOwn  (pbNone),
    .altOe   (pbNone),
    .altOut  (pbNone),
    .pinIn   (pbIn),
    .pinOut  (pbOut),
    .pinOe   (pbOe),
    .pullEn  (pbPullEn),
    .rdDir   (rdDir[pppc_pkg::IDX_PB]),
    .rdLatch (rdLatch[pppc_pkg::IDX_PB]),
    .rdPin   (rdPin[pppc_pkg::IDX_PB]),
    .rdCtl   (rdCtl[pppc_pkg::IDX_PB])
  );

  pppc_port #(.W(pppc_pkg::W_PC), .HAS_PU(1'b1)) u_pc (
    .mclk    (mclk),
    .rst     (rst),
    .wrDir   (wrDir[pppc_pkg::IDX_PC]),
    .wrLatch (wrLatch[pppc_pkg::IDX_PC]),
    .wrCtl   (wrCtl[pppc_pkg::IDX_PC]),
    .wrData  (wData_r[15:0]),
    .wrStrb  (wStrb_r[1:0]),
    .addrSel (pcAddrSel),
    .addrVal (addrBus[7:0]),
    .altOwn  (pcNone),
    .altOe   (pcNone),
    .altOut  (pcNone),
    .pinIn   (pcIn),
    .pinOut  (pcOut),
    .pinOe   (pcOe),
    .pullEn  (pcPullEn),
    .rdDir   (rdDir[pppc_pkg::IDX_PC]),
    .rdLatch (rdLatch[pppc_pkg::IDX_PC]),
    .rdPin   (rdPin[pppc_pkg::IDX_PC]),
    .rdCtl   (rdCtl[pppc_pkg::IDX_PC])
  );
endmodule

//--- tb/pppc_pin_model.sv
// Board model of one port's pin levels
`timescale 1ns/1ps
module pppc_pin_model #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic [W-1:0] drvOut,
  input  wire logic [W-1:0] drvOe,
  input  wire logic [W-1:0] pullEn,
  input  wire logic [7:0]   ext,
  input  wire logic         extEn,
  output logic      [W-1:0] pinLvl
);
  logic [W-1:0] flt = '0;
  // Floating line toggles every cycle
  always @(posedge mclk)
    flt <= ~flt;
  assign pinLvl = (drvOe & drvOut)
                | (~drvOe & (extEn ? ext[W-1:0] : (pullEn | flt)));
endmodule

//--- tb/pppc_sva.sv
// Port-level assertions for the port pin control top
`timescale 1ns/1ps
module pppc_sva (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [23:0] addrBus,
  input wire logic [7:0]  p2AltOwn,
  input wire logic [7:0]  p2AltOe,
  input wire logic [7:0]  p2AltOut,
  input wire logic [7:0]  p2Out,
  input wire logic [7:0]  p2Oe,
  input wire logic [3:0]  paOut,
  input wire logic [3:0]  paOe,
  input wire logic [7:0]  pbOut,
  input wire logic [7:0]  pbOe,
  input wire logic [7:0]  pbPullEn,
  input wire logic [7:0]  pcOut,
  input wire logic [7:0]  pcOe,
  input wire logic [2:0]  modeOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence respLate;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  chk_write_resp: assert property (wrTake |=> respLate)
    else $error("late write response");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp not held");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata not held");
  chk_read_resp: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("late read data");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar taken while busy");
  chk_reset_state: assert property ($past(rst) |->
    modeOut == 3'h7 && paOe == 4'h0 && pbOe == 8'h00)
    else $error("bad reset state");
  chk_fixed_addr: assert property (modeOut == 3'h1 |->
    pbOe == 8'hff && pcOe == 8'hff && pbOut == addrBus[15:8] &&
    pcOut == addrBus[7:0])
    else $error("bad mode 1 address");
  chk_pa_addr: assert property (modeOut inside {3'h4, 3'h5} |->
    paOut == addrBus[19:16])
    else $error("bad port A address");
  chk_p2_override: assert property ((p2Oe & p2AltOwn)
    == (p2AltOe & p2AltOwn) && (p2Out & p2AltOwn & p2AltOe)
    == (p2AltOut & p2AltOwn & p2AltOe))
    else $error("port 2 override lost");
  chk_pull_off: assert property ((pbPullEn & pbOe) == 8'h00)
    else $error("pull-up on driven pin");
endmodule

//--- tb/pppc_top_test.sv
// Register-level bench for the port pin control top
`timescale 1ns/1ps
module pppc_top_test;
  localparam OK = pppc_pkg::RESP_OKAY;
  localparam ERR = pppc_pkg::RESP_SLVERR;
  localparam D = pppc_pkg::SEL_DIR;
  localparam L = pppc_pkg::SEL_LATCH;
  localparam P = pppc_pkg::SEL_PIN;
  localparam C = pppc_pkg::SEL_CTL;
  localparam MR = pppc_pkg::OFS_MODE;
  logic mclk, rst, extEn;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ext;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] addrBus;
  logic [2:0] modeOut;
  logic [7:0] p1In, p1Out, p1Oe, p1AltOwn, p1AltOe, p1AltOut;
  logic [7:0] p2In, p2Out, p2Oe, p2AltOwn, p2AltOe, p2AltOut;
  logic [5:0] p3In, p3Out, p3Oe, p3AltOwn, p3AltOe, p3AltOut;
  logic [3:0] p5In, p5Out, p5Oe, p5AltOwn, p5AltOe, p5AltOut;
  logic [3:0] p4In, paIn, paOut, paOe, paPullEn;
  logic [7:0] pbIn, pbOut, pbOe, pbPullEn, pcIn, pcOut, pcOe, pcPullEn;
  logic [7:0] msk [7] = '{8'hff, 8'hff, 8'h3f, 8'h0f, 8'h0f, 8'hff, 8'hff};
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  pppc_top DUT (.*);
  pppc_pin_model #(8) M1 (.mclk, .drvOut(p1Out), .drvOe(p1Oe),
    .pullEn(8'h00), .ext, .extEn, .pinLvl(p1In));
  pppc_pin_model #(8) M2 (.mclk, .drvOut(p2Out), .drvOe(p2Oe),
    .pullEn(8'h00), .ext, .extEn, .pinLvl(p2In));
  pppc_pin_model #(6) M3 (.mclk, .drvOut(p3Out), .drvOe(p3Oe),
    .pullEn(6'h00), .ext, .extEn, .pinLvl(p3In));
  assign p4In = ext[3:0];
  pppc_pin_model #(4) M5 (.mclk, .drvOut(p5Out), .drvOe(p5Oe),
    .pullEn(4'h0), .ext, .extEn, .pinLvl(p5In));
  pppc_pin_model #(4) MA (.mclk, .drvOut(paOut), .drvOe(paOe),
    .pullEn(paPullEn), .ext, .extEn, .pinLvl(paIn));
  pppc_pin_model #(8) MB (.mclk, .drvOut(pbOut), .drvOe(pbOe),
    .pullEn(pbPullEn), .ext, .extEn, .pinLvl(pbIn));
  pppc_pin_model #(8) MC (.mclk, .drvOut(pcOut), .drvOe(pcOe),
    .pullEn(pcPullEn), .ext, .extEn, .pinLvl(pcIn));
  function automatic logic [7:0] ad(input int i, input logic [1:0] s);
    return {1'b0, i[2:0], s, 2'b00};
  endfunction
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    logic ta, tw, tb;
    logic [1:0] br;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge mclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    cmp(32'(br), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] rr;
    @(posedge mclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge mclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    cmp(d, e);
    cmp(32'(rr), 32'(r));
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  initial
  begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = '0;
    {p1AltOwn, p1AltOe, p1AltOut, p2AltOwn, p2AltOe, p2AltOut} = '0;
    {p3AltOwn, p3AltOe, p3AltOut, p5AltOwn, p5AltOe, p5AltOut} = '0;
    addrBus = 24'h9c3e71;
    ext = 8'h3c;
    extEn = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(MR, 32'h7, OK);
    for (int i = 0; i < 7; i++)
    begin
      rd(ad(i, D), 32'h0, OK);
      wr(ad(i, L), 32'ha5, 4'h1, OK);
      wr(ad(i, D), 32'hff, 4'h1, OK);
      rd(ad(i, D), 32'(msk[i]), OK);
      rd(ad(i, P), 32'(8'ha5 & msk[i]), OK);
      wr(ad(i, D), 32'h0, 4'h1, OK);
      rd(ad(i, P), 32'(8'h3c & msk[i]), OK);
    end
    wr(MR, 32'h1, 4'h1, OK);
    wr(MR, 32'h4, 4'h1, OK);
    @(negedge mclk);
    cmp(32'(p1Oe), 32'h0);
    wr(ad(0, D), 32'h0f, 4'h1, OK);
    wr(MR, 32'h0, 4'h1, OK);
    rd(MR, 32'h4, OK);
    @(negedge mclk);
    cmp(32'(p1Oe), 32'h0f);
    cmp(32'(p1Out[3:0]), 32'(addrBus[23:20]));
    wr(MR, 32'h7, 4'h1, OK);
    wr(ad(5, C), 32'hff, 4'h1, OK);
    wr(ad(0, C), 32'hff, 4'h1, OK);
    extEn <= 1'b0;
    rd(ad(0, C), 32'h0, OK);
    rd(ad(5, P), 32'hff, OK);
    cmp(32'(pbPullEn), 32'hff);
    wr(ad(2, C), 32'h3f00, 4'h2, OK);
    rd(ad(2, C), 32'h3f00, OK);
    wr(ad(2, L), 32'h3f, 4'h1, OK);
    wr(ad(2, D), 32'h3f, 4'h1, OK);
    @(negedge mclk);
    cmp(32'(p3Oe), 32'h0);
    wr(ad(2, L), 32'h05, 4'h1, OK);
    @(negedge mclk);
    cmp(32'(p3Oe), 32'h3a);
    extEn <= 1'b1;
    {p1AltOwn, p1AltOe, p1AltOut} <= {8'hf0, 8'h30, 8'hff};
    {p2AltOwn, p2AltOe, p2AltOut} <= {8'hff, 8'h0f, 8'h5a};
    {p3AltOwn, p3AltOe, p3AltOut} <= {6'h03, 6'h03, 6'h02};
    {p5AltOwn, p5AltOe, p5AltOut} <= {4'hf, 4'hf, 4'hf};
    wr(ad(3, D), 32'hf, 4'h1, OK);
    @(negedge mclk);
    cmp(32'(p1Oe[7:4]), 32'h3);
    cmp(32'(p1Out[5:4]), 32'h3);
    cmp(32'(p3Oe), 32'h39);
    cmp(32'(p5Out), 32'h7);
    cmp(32'(p5Oe), 32'hf);
    rd(ad(1, P), 32'h3a, OK);
    rd(ad(7, P), 32'h0c, OK);
    wr(ad(7, D), 32'hf, 4'h1, ERR);
    rd(ad(7, L), 32'h0, ERR);
    rd(8'h90, 32'h0, ERR);
    wr(8'h90, 32'h1, 4'h1, ERR);
    end_sim;
  end
endmodule
bind pppc_top pppc_sva CHK (.*);
